// ==== rtl/cc_array_pkg.sv ====
// How it works
// - rising-capture enable alone captures the counter on each rising pin edge.
// - falling-capture enable alone captures the counter on each falling pin edge.
// - both capture enables capture on every pin transition.
// - a capture copies all sixteen counter bits into the compare high and low bytes.
// - each capture overwrites the stored value with no protection.
// - capture or match sets the event flag; interrupt needs flag and enable.
// - hardware only sets event flags; software clears them.
// - comparator plus compare-hit enables give a software timer flagging on equality.
// - writing the low byte stops matching; writing the high byte restarts it.
// - pin-flip, compare-hit and comparator set invert the pin on each match.
// - the pin inverts in hardware at the match, not by interrupt service.
// - high-speed output toggles whatever the interrupt enable holds.
// - without a new compare value the next toggle comes after counter wrap.
// - comparator plus pulse-width enable, compare-hit clear, select pulse-width output; interrupt unused.
// - watchdog only on module four, comparator and compare-hit set, pulse-width clear.
// - watchdog drives internal reset only with the watchdog reset enable set.
// - pin-flip zero leaves the pin on a match; one inverts it.
// - all five modules share one free-running sixteen-bit counter.
// - mode bits: 0 irq, 1 pwm, 2 flip, 3 hit, 4 fall, 5 rise, 6 comparator.
// - pulse-width output low while counter low byte is below compare low byte.
package cc_array_pkg;
   localparam int          NUM_MODULES    = 5;
   localparam int          WDT_MODULE     = 4;
   localparam logic [11:0] ADDR_CTRL      = 12'h000;
   localparam logic [11:0] ADDR_ARRAY_MODE_REGISTER      = 12'h004;
   localparam logic [11:0] ADDR_CNT_LO    = 12'h008;
   localparam logic [11:0] ADDR_CNT_HI    = 12'h00C;
   localparam logic [11:0] ADDR_MODE_BASE = 12'h010;
   localparam logic [11:0] ADDR_CAPL_BASE = 12'h030;
   localparam logic [11:0] ADDR_CAPH_BASE = 12'h050;
   localparam int          MODE_IRQ       = 0;
   localparam int          MODE_PWM       = 1;
   localparam int          MODE_FLIP      = 2;
   localparam int          MODE_HIT       = 3;
   localparam int          MODE_FALL      = 4;
   localparam int          MODE_RISE      = 5;
   localparam int          MODE_COMP      = 6;
   localparam int          CTRL_RUN       = 6;
   localparam int          ARRAY_MODE_REGISTER_WATCHDOG_RESET_ENABLE      = 6;
   localparam logic [7:0]  MODE_RESET     = 8'h00;
   localparam logic [7:0]  CAP_RESET      = 8'h00;
   localparam logic [1:0]  RESP_OKAY      = 2'b00;
   localparam logic [1:0]  RESP_SLVERR    = 2'b10;
endpackage : cc_array_pkg

// ==== rtl/cc_array.sv ====
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module cc_array #(
   parameter int N = 5
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         clk_en,
   input  wire logic         count_tick,
   input  wire logic [N-1:0] module_pin_in,
   output logic      [N-1:0] module_pin_out,
   output logic      [N-1:0] module_pin_oe,
   output logic              irq,
   output logic              wdt_reset,
   input  wire logic [11:0]  s_axi_awaddr,
   input  wire logic         s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   input  wire logic         s_axi_wvalid,
   output logic              s_axi_wready,
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire logic         s_axi_bready,
   input  wire logic [11:0]  s_axi_araddr,
   input  wire logic         s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire logic         s_axi_rready
);
   logic [15:0]   counter_reg;
   logic [7:0]    ctrl_reg;
   logic [7:0]    array_mode_register_reg;
   logic [N-1:0]  flag_reg;
   logic [6:0]    mode_reg [N];
   logic [7:0]    caph_reg [N];
   logic [7:0]    capl_reg [N];
   logic [N-1:0]  cmp_arm_reg;
   logic [N-1:0]  pin_prev_reg;
   logic [N-1:0]  pin_reg;
   logic [N-1:0]  cap_ev;
   logic [N-1:0]  hit_ev;
   logic [11:0]   aw_reg;
   logic [31:0]   wd_reg;
   logic [3:0]    ws_reg;
   logic          aw_full_reg;
   logic          w_full_reg;
   logic          wr_go;
   logic          wr_ok;
   logic          rd_ok;
   logic [31:0]   rd_val;
   logic          running;
   logic          wr_ctrl;
   logic          tick_prev_reg;

   // decode a byte address into a module slot within a bank
   function automatic logic slot_hit(input logic [11:0] a, input logic [11:0] base,
                                     input int idx);
      slot_hit = (a == base + 12'(idx * 4));
   endfunction : slot_hit

   function automatic logic addr_known(input logic [11:0] a);
      addr_known = 1'b0;
      if (a == cc_array_pkg::ADDR_CTRL || a == cc_array_pkg::ADDR_ARRAY_MODE_REGISTER ||
          a == cc_array_pkg::ADDR_CNT_LO || a == cc_array_pkg::ADDR_CNT_HI) begin
         addr_known = 1'b1;
      end
      for (int i = 0; i < N; i++) begin
         if (slot_hit(a, cc_array_pkg::ADDR_MODE_BASE, i) ||
             slot_hit(a, cc_array_pkg::ADDR_CAPL_BASE, i) ||
             slot_hit(a, cc_array_pkg::ADDR_CAPH_BASE, i)) begin
            addr_known = 1'b1;
         end
      end
   endfunction : addr_known

   assign running = ctrl_reg[cc_array_pkg::CTRL_RUN];

   // write channel: address and data taken in either order
   assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
   assign wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;
   assign wr_ok = wr_go && clk_en && addr_known(aw_reg) && ws_reg[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg  <= 1'b0;
         w_full_reg   <= 1'b0;
         aw_reg       <= 12'h000;
         wd_reg       <= 32'h00000000;
         ws_reg       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= cc_array_pkg::RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_reg      <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            wd_reg     <= s_axi_wdata;
            ws_reg     <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_known(aw_reg) ? cc_array_pkg::RESP_OKAY
                                               : cc_array_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read channel
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_ok = s_axi_arvalid && s_axi_arready;

   always_comb begin
      rd_val = 32'h00000000;
      unique case (s_axi_araddr)
         cc_array_pkg::ADDR_CTRL:   rd_val = {24'h000000, ctrl_reg[7:N], flag_reg};
         cc_array_pkg::ADDR_ARRAY_MODE_REGISTER:   rd_val = {24'h000000, array_mode_register_reg};
         cc_array_pkg::ADDR_CNT_LO: rd_val = {24'h000000, counter_reg[7:0]};
         cc_array_pkg::ADDR_CNT_HI: rd_val = {24'h000000, counter_reg[15:8]};
         default:                   rd_val = 32'h00000000;
      endcase
      for (int i = 0; i < N; i++) begin
         // reserved mode bit reads as zero
         if (slot_hit(s_axi_araddr, cc_array_pkg::ADDR_MODE_BASE, i)) begin
            rd_val = {25'h0000000, mode_reg[i]};
         end
         if (slot_hit(s_axi_araddr, cc_array_pkg::ADDR_CAPL_BASE, i)) begin
            rd_val = {24'h000000, capl_reg[i]};
         end
         if (slot_hit(s_axi_araddr, cc_array_pkg::ADDR_CAPH_BASE, i)) begin
            rd_val = {24'h000000, caph_reg[i]};
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= cc_array_pkg::RESP_OKAY;
      end else if (clk_en) begin
         if (rd_ok) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= addr_known(s_axi_araddr) ? cc_array_pkg::RESP_OKAY
                                                     : cc_array_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // control, array mode and shared counter
   assign wr_ctrl = wr_ok && aw_reg == cc_array_pkg::ADDR_CTRL;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= 8'h00;
         array_mode_register_reg <= 8'h00;
      end else if (clk_en) begin
         if (wr_ctrl) begin
            ctrl_reg <= wd_reg[7:0];
         end
         if (wr_ok && aw_reg == cc_array_pkg::ADDR_ARRAY_MODE_REGISTER) begin
            array_mode_register_reg <= wd_reg[7:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         counter_reg   <= 16'h0000;
         tick_prev_reg <= 1'b0;
      end else if (clk_en) begin
         tick_prev_reg <= running && count_tick;
         if (wr_ok && aw_reg == cc_array_pkg::ADDR_CNT_LO) begin
            counter_reg[7:0] <= wd_reg[7:0];
         end else if (wr_ok && aw_reg == cc_array_pkg::ADDR_CNT_HI) begin
            counter_reg[15:8] <= wd_reg[7:0];
         end else if (running && count_tick) begin
            counter_reg <= counter_reg + 16'h0001;
         end
      end
   end

   // event flags: hardware sets, software clears by writing zero; set wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_reg <= '0;
      end else if (clk_en) begin
         for (int i = 0; i < N; i++) begin
            if (cap_ev[i] || hit_ev[i]) begin
               flag_reg[i] <= 1'b1;
            end else if (wr_ctrl && !wd_reg[i]) begin
               flag_reg[i] <= 1'b0;
            end
         end
      end
   end

   always_comb begin
      irq = 1'b0;
      for (int i = 0; i < N; i++) begin
         irq = irq | (flag_reg[i] & mode_reg[i][cc_array_pkg::MODE_IRQ]);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdt_reset <= 1'b0;
      end else if (clk_en) begin
         wdt_reset <= hit_ev[cc_array_pkg::WDT_MODULE] &&
                      !mode_reg[cc_array_pkg::WDT_MODULE][cc_array_pkg::MODE_PWM] &&
                      array_mode_register_reg[cc_array_pkg::ARRAY_MODE_REGISTER_WATCHDOG_RESET_ENABLE];
      end
   end

   // per-module capture, compare and output
   for (genvar g = 0; g < N; g++) begin : g_mod
      logic rise_ev;
      logic fall_ev;
      logic comp_on;
      logic hit_mode;
      logic pwm_mode;
      assign comp_on  = mode_reg[g][cc_array_pkg::MODE_COMP];
      assign hit_mode = comp_on && mode_reg[g][cc_array_pkg::MODE_HIT];
      assign pwm_mode = comp_on && mode_reg[g][cc_array_pkg::MODE_PWM] &&
                        !mode_reg[g][cc_array_pkg::MODE_HIT];
      assign rise_ev  = pin_reg[g] && !pin_prev_reg[g];
      assign fall_ev  = !pin_reg[g] && pin_prev_reg[g];
      assign cap_ev[g] = !comp_on &&
                         ((rise_ev && mode_reg[g][cc_array_pkg::MODE_RISE]) ||
                          (fall_ev && mode_reg[g][cc_array_pkg::MODE_FALL]));
      // one check per increment, full sixteen bits, armed at reset and after high byte, disarmed by low byte
      assign hit_ev[g] = hit_mode && tick_prev_reg && cmp_arm_reg[g] &&
                         counter_reg == {caph_reg[g], capl_reg[g]};

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            pin_reg[g]      <= 1'b0;
            pin_prev_reg[g] <= 1'b0;
         end else if (clk_en) begin
            pin_reg[g]      <= module_pin_in[g];
            pin_prev_reg[g] <= pin_reg[g];
         end
      end

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            mode_reg[g]    <= cc_array_pkg::MODE_RESET[6:0];
            capl_reg[g]    <= cc_array_pkg::CAP_RESET;
            caph_reg[g]    <= cc_array_pkg::CAP_RESET;
            cmp_arm_reg[g] <= 1'b1;
         end else if (clk_en) begin
            if (wr_ok && slot_hit(aw_reg, cc_array_pkg::ADDR_MODE_BASE, g)) begin
               mode_reg[g] <= wd_reg[6:0];
            end
            if (cap_ev[g]) begin
               {caph_reg[g], capl_reg[g]} <= counter_reg;
            end else if (wr_ok && slot_hit(aw_reg, cc_array_pkg::ADDR_CAPL_BASE, g)) begin
               capl_reg[g]    <= wd_reg[7:0];
               cmp_arm_reg[g] <= 1'b0;
            end else if (wr_ok && slot_hit(aw_reg, cc_array_pkg::ADDR_CAPH_BASE, g)) begin
               caph_reg[g]    <= wd_reg[7:0];
               cmp_arm_reg[g] <= 1'b1;
            end
         end
      end

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            module_pin_out[g] <= 1'b0;
         end else if (clk_en) begin
            if (pwm_mode) begin
               module_pin_out[g] <= !(counter_reg[7:0] < capl_reg[g]);
            end else if (hit_ev[g] && mode_reg[g][cc_array_pkg::MODE_FLIP]) begin
               module_pin_out[g] <= !module_pin_out[g];
            end
         end
      end

      assign module_pin_oe[g] = pwm_mode || (hit_mode && mode_reg[g][cc_array_pkg::MODE_FLIP]);
   end

   property p_capture_copies;
      @(posedge aclk) disable iff (!aresetn)
      (clk_en && cap_ev[0]) |=> ({caph_reg[0], capl_reg[0]} == $past(counter_reg));
   endproperty
   a_capture_copies: assert property (p_capture_copies) else $error("capture lost");

   property p_flag_set;
      @(posedge aclk) disable iff (!aresetn)
      (clk_en && (cap_ev[1] || hit_ev[1])) |=> flag_reg[1];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set");

   property p_flag_hold;
      @(posedge aclk) disable iff (!aresetn)
      (flag_reg[0] && !(clk_en && wr_ctrl && !wd_reg[0])) |=> flag_reg[0];
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

   property p_low_disarms;
      @(posedge aclk) disable iff (!aresetn)
      (clk_en && wr_ok && slot_hit(aw_reg, cc_array_pkg::ADDR_CAPL_BASE, 0) && !cap_ev[0])
      |=> !hit_ev[0];
   endproperty
   a_low_disarms: assert property (p_low_disarms) else $error("match while disarmed");

   property p_toggle;
      @(posedge aclk) disable iff (!aresetn)
      (clk_en && hit_ev[1] && mode_reg[1][cc_array_pkg::MODE_FLIP] &&
       !mode_reg[1][cc_array_pkg::MODE_PWM]) |=> (module_pin_out[1] != $past(module_pin_out[1]));
   endproperty
   a_toggle: assert property (p_toggle) else $error("no toggle");

   property p_no_flip;
      @(posedge aclk) disable iff (!aresetn)
      (clk_en && !mode_reg[0][cc_array_pkg::MODE_FLIP] && !mode_reg[0][cc_array_pkg::MODE_PWM])
      |=> $stable(module_pin_out[0]);
   endproperty
   a_no_flip: assert property (p_no_flip) else $error("pin moved");

   property p_wdt;
      @(posedge aclk) disable iff (!aresetn)
      wdt_reset |-> $past(array_mode_register_reg[cc_array_pkg::ARRAY_MODE_REGISTER_WATCHDOG_RESET_ENABLE]);
   endproperty
   a_wdt: assert property (p_wdt) else $error("reset without enable");

   property p_pwm;
      @(posedge aclk) disable iff (!aresetn)
      (clk_en && g_mod[2].pwm_mode) |=> (module_pin_out[2] == ($past(counter_reg[7:0]) >=
                                                              $past(capl_reg[2])));
   endproperty
   a_pwm: assert property (p_pwm) else $error("pwm level wrong");
endmodule : cc_array

// ==== bench/cc_pin_model.sv ====
`timescale 1ns/1ps
module cc_pin_model (
   input  wire logic [4:0] drive_lvl,
   input  wire logic [4:0] pin_out,
   input  wire logic [4:0] pin_oe,
   output logic      [4:0] pin_in
);
   // wire level: the module where it drives, the far side elsewhere
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : drive_lvl[i];
      end
   end
endmodule : cc_pin_model

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
   localparam logic [1:0] OK  = cc_array_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = cc_array_pkg::RESP_SLVERR;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, irq, wdt_reset, ep, flag;
   logic        ce;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rsp;
   logic [4:0]  pin_in, pin_out, pin_oe, drive_lvl;
   logic [15:0] c, c2, expc;
   logic [7:0]  lo, x;
   logic [7:0]  cap_modes [3];
   int          bad_count, compares, cycles, seed, wdt_pulses, m, e, i;

   cc_array #(.N(5)) i_cc_array (
      .aclk(aclk), .aresetn(aresetn), .clk_en(ce), .count_tick(1'b1),
      .module_pin_in(pin_in), .module_pin_out(pin_out), .module_pin_oe(pin_oe),
      .irq(irq), .wdt_reset(wdt_reset),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   cc_pin_model i_cc_pin_model (
      .drive_lvl(drive_lvl), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   always @(posedge aclk) begin
      cycles++;
      if (wdt_reset === 1'b1) wdt_pulses++;
      if (cycles == 20000) begin
         bad_count++;
         give_verdict();
      end
   end

   task automatic give_verdict;
      $display("counts: compares=%0d bad=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : give_verdict

   task automatic check32(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check32

   task automatic check1(input logic got, input logic exp);
      check32({31'h0, got}, {31'h0, exp});
   endtask : check1

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_h, w_h, b_h;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      b_h = 1'b0;
      while (!b_h) begin
         @(posedge aclk);
         aw_h = awvalid & awready;
         w_h  = wvalid & wready;
         b_h  = bvalid;
         rsp  = bresp;
         if (aw_h) awvalid <= 1'b0;
         if (w_h) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      check32({30'h0, rsp}, {30'h0, er});
   endtask : wr

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic ar_h, r_h;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      r_h = 1'b0;
      while (!r_h) begin
         @(posedge aclk);
         ar_h = arvalid & arready;
         r_h  = rvalid;
         rd   = rdata;
         rsp  = rresp;
         if (ar_h) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      check32(rd, exp);
      check32({30'h0, rsp}, {30'h0, er});
   endtask : rd_chk

   function automatic logic [11:0] at(input logic [11:0] base, input int n);
      return base + 12'(4 * n);
   endfunction : at

   task automatic set_cnt(input logic [15:0] v);
      wr(cc_array_pkg::ADDR_CNT_LO, {24'h0, v[7:0]}, OK);
      wr(cc_array_pkg::ADDR_CNT_HI, {24'h0, v[15:8]}, OK);
   endtask : set_cnt

   task automatic set_cmp(input int n, input logic [15:0] v);
      wr(at(cc_array_pkg::ADDR_CAPL_BASE, n), {24'h0, v[7:0]}, OK);
      wr(at(cc_array_pkg::ADDR_CAPH_BASE, n), {24'h0, v[15:8]}, OK);
   endtask : set_cmp

   // counter runs from start across a point four counts ahead, flags kept
   task automatic run_pass(input logic [15:0] start);
      set_cnt(start);
      wr(cc_array_pkg::ADDR_CTRL, 32'h5F, OK);
      repeat (12) @(posedge aclk);
      wr(cc_array_pkg::ADDR_CTRL, 32'h1F, OK);
   endtask : run_pass

   initial begin
      seed = 18;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, wstrb} = '0;
      wstrb = 4'hF;
      drive_lvl = 5'h00;
      ce = 1'b1;
      aresetn = 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      for (m = 0; m < 5; m++) begin
         rd_chk(at(cc_array_pkg::ADDR_MODE_BASE, m), {24'h0, cc_array_pkg::MODE_RESET}, OK);
      end
      rd_chk(cc_array_pkg::ADDR_CAPL_BASE, {24'h0, cc_array_pkg::CAP_RESET}, OK);
      rd_chk(12'h0F0, 32'h0, ERR);
      wr(12'h0F4, 32'h1, ERR);
      $display("test reset done");
      cap_modes = '{8'h20, 8'h10, 8'h31};
      for (m = 0; m < 3; m++) begin
         wr(at(cc_array_pkg::ADDR_MODE_BASE, m), {24'h0, cap_modes[m]}, OK);
         rd_chk(at(cc_array_pkg::ADDR_MODE_BASE, m), {24'h0, cap_modes[m]}, OK);
         flag = 1'b0;
         expc = 16'h0000;
         for (e = 0; e < 2; e++) begin
            c = 16'($random(seed));
            set_cnt(c);
            @(posedge aclk);
            drive_lvl[m] <= ~drive_lvl[m];
            repeat (6) @(posedge aclk);
            if (cap_modes[m][5-e]) begin
               expc = c;
               flag = 1'b1;
            end
            rd_chk(at(cc_array_pkg::ADDR_CAPL_BASE, m), {24'h0, expc[7:0]}, OK);
            rd_chk(at(cc_array_pkg::ADDR_CAPH_BASE, m), {24'h0, expc[15:8]}, OK);
            rd_chk(cc_array_pkg::ADDR_CTRL, 32'(flag) << m, OK);
            check1(irq, flag & cap_modes[m][0]);
         end
         wr(cc_array_pkg::ADDR_CTRL, 32'h0, OK);
      end
      $display("test capture done");
      wr(cc_array_pkg::ADDR_MODE_BASE, 32'h48, OK);
      c = 16'($random(seed));
      c2 = c + 16'h0100;
      set_cmp(0, c);
      run_pass(c - 16'd4);
      rd_chk(cc_array_pkg::ADDR_CTRL, 32'h1, OK);
      check1(pin_out[0], 1'b0);
      wr(cc_array_pkg::ADDR_CTRL, 32'h0, OK);
      wr(cc_array_pkg::ADDR_CAPL_BASE, {24'h0, c2[7:0]}, OK);
      run_pass(c - 16'd4);
      rd_chk(cc_array_pkg::ADDR_CTRL, 32'h0, OK);
      wr(cc_array_pkg::ADDR_CAPH_BASE, {24'h0, c2[15:8]}, OK);
      run_pass(c2 - 16'd4);
      rd_chk(cc_array_pkg::ADDR_CTRL, 32'h1, OK);
      wr(cc_array_pkg::ADDR_CTRL, 32'h0, OK);
      $display("test timer done");
      ep = 1'b0;
      for (i = 0; i < 2; i++) begin
         wr(at(cc_array_pkg::ADDR_MODE_BASE, 1), 32'h4C | 32'(i), OK);
         c = 16'($random(seed));
         set_cmp(1, c);
         repeat (2) begin
            run_pass(c - 16'd4);
            ep = ~ep;
            check1(pin_out[1], ep);
         end
         check1(pin_oe[1], 1'b1);
         check1(irq, i[0]);
      end
      wr(cc_array_pkg::ADDR_CTRL, 32'h0, OK);
      $display("test toggle done");
      wr(at(cc_array_pkg::ADDR_MODE_BASE, 2), 32'h42, OK);
      lo = 8'h10 + 8'($unsigned($random(seed)) % 224);
      set_cmp(2, {lo, lo});
      for (i = -1; i < 2; i++) begin
         x = lo + 8'(i);
         set_cnt({8'h00, x});
         repeat (4) @(posedge aclk);
         check1(pin_out[2], x >= lo);
      end
      $display("test pwm done");
      set_cnt(16'h0000);
      wr(cc_array_pkg::ADDR_CTRL, 32'h40, OK);
      ce <= 1'b0;
      repeat (10) @(posedge aclk);
      ce <= 1'b1;
      repeat (2) @(posedge aclk);
      wr(cc_array_pkg::ADDR_CTRL, 32'h0, OK);
      // one count after the run edge, five from the thaw to the stop edge
      rd_chk(cc_array_pkg::ADDR_CNT_LO, 32'h6, OK);
      $display("test freeze done");
      wr(at(cc_array_pkg::ADDR_MODE_BASE, 4), 32'h48, OK);
      c = 16'($random(seed));
      set_cmp(4, c);
      wdt_pulses = 0;
      run_pass(c - 16'd4);
      check32(32'(wdt_pulses), 32'h0);
      wr(cc_array_pkg::ADDR_ARRAY_MODE_REGISTER, 32'h40, OK);
      run_pass(c - 16'd4);
      check32(32'(wdt_pulses), 32'h1);
      rd_chk(cc_array_pkg::ADDR_CTRL, 32'h10, OK);
      run_pass(c2 - 16'd4);
      check32(32'(wdt_pulses), 32'h1);
      $display("test watchdog done");
      give_verdict();
   end
endmodule : tb
